/* logic/pwm_wave_outputs.sv */
`timescale 1ns/1ps
`include "pwm_wave_regs.svh"

module pwm_wave_outputs
  import pwm_wave_pkg::*;
#(
  parameter int PINS = 16
) (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [15:0] pins_o
);

  localparam logic [5:0]  TICK_LAST = 6'(`TICK_CYCLES - 1);
  localparam logic [31:0] STEP_MAX  = 32'(`SQ_STEP_MAX);

  pwm_wave_state_t st_reg;
  pwm_wave_state_t st_next;
  logic [PINS-1:0] level;
  logic            req;
  logic [31:0]     wmask;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  assign req   = avs_read_i | avs_write_i;
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin selection between the pulse-width and the square-wave source.

  generate
    for (genvar i = 0; i < PINS; i++) begin : g_pin
      assign level[i] = st_reg.pin_en[i] &
                        (st_reg.pin_sel[i] ?
                         (st_reg.sq_acc[31:24] < st_reg.sq_duty[i]) :
                         st_reg.pwm_out);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic [31:0] wv;
    logic [31:0] step_w;
    wv      = 32'h0000_0000;
    step_w  = 32'h0000_0000;
    st_next = st_reg;

    // One-microsecond tick from the system clock.
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == TICK_LAST) begin
      st_next.tick_cnt = 6'h00;
      st_next.tick     = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 6'h01;
    end

    // The period in ticks is also the number of duty steps.
    if (st_reg.tick) begin
      if (st_reg.pwm_cnt >= st_reg.pwm_period - 16'h0001) begin
        st_next.pwm_cnt = 16'h0000;
      end else begin
        st_next.pwm_cnt = st_reg.pwm_cnt + 16'h0001;
      end
    end
    // A duty at or above the period stays high even while the counter catches up with a
    // shortened period.
    st_next.pwm_out = (st_reg.pwm_cnt < st_reg.pwm_duty) ||
                      (st_reg.pwm_duty >= st_reg.pwm_period);

    // A zero step leaves the phase, and with it every square-source pin, standing still.
    st_next.sq_acc = st_reg.sq_acc + st_reg.sq_step;
    st_next.pins   = level[15:0];

    // Bus slave: one wait state, then the access completes.
    st_next.bus_wait = ~(req & st_reg.bus_wait);
    if (req && st_reg.bus_wait) begin
      unique case (avs_address_i)
        `PIN_EN_OFS:     st_next.rdata = {16'h0000, st_reg.pin_en};
        `PIN_SEL_OFS:    st_next.rdata = {16'h0000, st_reg.pin_sel};
        `PWM_PERIOD_OFS: st_next.rdata = {16'h0000, st_reg.pwm_period};
        `PWM_DUTY_OFS:   st_next.rdata = {16'h0000, st_reg.pwm_duty};
        `SQ_STEP_OFS:    st_next.rdata = st_reg.sq_step;
        `STATUS_OFS: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rdata[`STATUS_PINS_LSB +: 16] = st_reg.pins;
          st_next.rdata[`STATUS_PWM_BIT]        = st_reg.pwm_out;
        end
        default: begin
          if (avs_address_i[7:6] == 2'(`SQ_DUTY_BASE >> 6) && avs_address_i[1:0] == 2'b00) begin
            st_next.rdata = {24'h000000,
                             st_reg.sq_duty[avs_address_i[`SQ_DUTY_IDX_MSB:`SQ_DUTY_IDX_LSB]]};
          end else begin
            st_next.rdata = 32'h0000_0000;
          end
        end
      endcase
    end

    if (avs_write_i && !st_reg.bus_wait) begin
      unique case (avs_address_i)
        `PIN_EN_OFS: begin
          wv = merge({16'h0000, st_reg.pin_en}, avs_writedata_i, wmask);
          st_next.pin_en = wv[15:0];
        end
        `PIN_SEL_OFS: begin
          wv = merge({16'h0000, st_reg.pin_sel}, avs_writedata_i, wmask);
          st_next.pin_sel = wv[15:0];
        end
        `PWM_PERIOD_OFS: begin
          wv = merge({16'h0000, st_reg.pwm_period}, avs_writedata_i, wmask);
          // A period below one tick would exceed one megahertz.
          st_next.pwm_period = (wv[15:0] == 16'h0000) ? 16'h0001 : wv[15:0];
        end
        `PWM_DUTY_OFS: begin
          wv = merge({16'h0000, st_reg.pwm_duty}, avs_writedata_i, wmask);
          st_next.pwm_duty = wv[15:0];
        end
        `SQ_STEP_OFS: begin
          step_w = merge(st_reg.sq_step, avs_writedata_i, wmask);
          st_next.sq_step = (step_w > STEP_MAX) ? STEP_MAX : step_w;
        end
        `STATUS_OFS: begin
          st_next.sq_step = st_reg.sq_step;
        end
        default: begin
          if (avs_address_i[7:6] == 2'(`SQ_DUTY_BASE >> 6) && avs_address_i[1:0] == 2'b00 &&
              avs_byteenable_i[0]) begin
            st_next.sq_duty[avs_address_i[`SQ_DUTY_IDX_MSB:`SQ_DUTY_IDX_LSB]] =
              avs_writedata_i[7:0];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_reg            <= '0;
      st_reg.pwm_period <= `PWM_PERIOD_RST;
      st_reg.pwm_duty   <= `PWM_DUTY_RST;
      st_reg.sq_step    <= `SQ_STEP_RST;
      st_reg.sq_duty    <= {16{`SQ_DUTY_RST}};
      st_reg.pin_en     <= `PIN_EN_RST;
      st_reg.pin_sel    <= `PIN_SEL_RST;
      st_reg.bus_wait   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata_o    = st_reg.rdata;
  assign avs_waitrequest_o = st_reg.bus_wait;
  assign pins_o            = st_reg.pins;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_tick_gap;
    !st_reg.tick [*8];
  endsequence

  property p_tick_spacing;
    st_reg.tick |=> s_tick_gap ##42 st_reg.tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("microsecond tick spacing wrong");

  property p_period_nonzero;
    st_reg.pwm_period != 16'h0000;
  endproperty
  a_period_nonzero: assert property (p_period_nonzero)
    else $error("pulse-width period is zero");

  property p_duty_zero_low;
    (st_reg.pwm_duty == 16'h0000) [*2] |-> !st_reg.pwm_out;
  endproperty
  a_duty_zero_low: assert property (p_duty_zero_low)
    else $error("zero duty gave a high output");

  property p_duty_full_high;
    (st_reg.pwm_duty >= st_reg.pwm_period && $stable(st_reg.pwm_duty)) [*2]
      |-> st_reg.pwm_out;
  endproperty
  a_duty_full_high: assert property (p_duty_full_high)
    else $error("full duty gave a low output");

  property p_wrap;
    st_reg.tick && st_reg.pwm_cnt >= st_reg.pwm_period - 16'h0001 |=> st_reg.pwm_cnt == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pulse-width counter did not wrap at its period");

  property p_step_max;
    st_reg.sq_step <= STEP_MAX;
  endproperty
  a_step_max: assert property (p_step_max)
    else $error("square-wave step above four megahertz");

  // Pin 0 on the square source with its duty and routing untouched and the phase frozen.
  sequence s_sq_frozen;
    st_reg.sq_step == 32'h0000_0000 && st_reg.pin_en[0] && st_reg.pin_sel[0] &&
      $stable(st_reg.sq_duty[0]) && $stable(st_reg.pin_en[0]) && $stable(st_reg.pin_sel[0]);
  endsequence

  property p_zero_hold;
    s_sq_frozen [*2] |=> $stable(st_reg.sq_acc) && $stable(st_reg.pins[0]);
  endproperty
  a_zero_hold: assert property (p_zero_hold)
    else $error("square-wave pin moved at zero frequency");

  property p_disabled_low;
    (st_reg.pin_en == 16'h0000) [*2] |-> pins_o == 16'h0000;
  endproperty
  a_disabled_low: assert property (p_disabled_low)
    else $error("unrouted pin is driven high");

  sequence s_bus_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence

  property p_bus_answer;
    s_bus_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus access not answered after one wait state");

endmodule // pwm_wave_outputs

/* logic/pwm_wave_regs.svh */
`ifndef PWM_WAVE_REGS_SVH
`define PWM_WAVE_REGS_SVH

// Register byte offsets.
`define PIN_EN_OFS      8'h00
`define PIN_SEL_OFS     8'h04
`define PWM_PERIOD_OFS  8'h08
`define PWM_DUTY_OFS    8'h0c
`define SQ_STEP_OFS     8'h10
`define STATUS_OFS      8'h14
`define SQ_DUTY_BASE    8'h40
`define SQ_DUTY_IDX_LSB 2
`define SQ_DUTY_IDX_MSB 5

// Status register field positions.
`define STATUS_PINS_LSB 0
`define STATUS_PWM_BIT  16

// Reset values.
`define PIN_EN_RST      16'h0000
`define PIN_SEL_RST     16'h0000
`define PWM_PERIOD_RST  16'h03e8
`define PWM_DUTY_RST    16'h01f4
`define SQ_STEP_RST     32'h0000_0000
`define SQ_DUTY_RST     8'h80

// Timing: one tick of the pulse-width counter is one microsecond.
`define CLK_PERIOD_NS   20
`define CLK_HZ          64'd50000000
`define TICK_NS         1000
`define TICK_CYCLES     (`TICK_NS / `CLK_PERIOD_NS)
`define SQ_MAX_HZ       64'd4000000
`define SQ_STEP_MAX     ((`SQ_MAX_HZ * 64'h1_0000_0000) / `CLK_HZ)

`endif

/* logic/pwm_wave_pkg.sv */
package pwm_wave_pkg;

  typedef struct packed {
    logic [5:0]       tick_cnt;
    logic             tick;
    logic [15:0]      pwm_period;
    logic [15:0]      pwm_duty;
    logic [15:0]      pwm_cnt;
    logic             pwm_out;
    logic [31:0]      sq_step;
    logic [31:0]      sq_acc;
    logic [15:0][7:0] sq_duty;
    logic [15:0]      pin_en;
    logic [15:0]      pin_sel;
    logic [15:0]      pins;
    logic             bus_wait;
    logic [31:0]      rdata;
  } pwm_wave_state_t;

endpackage

/* tb/pwm_wave_outputs_test.sv */
`timescale 1ns/1ps
`include "pwm_wave_regs.svh"

module pwm_wave_outputs_test;

  logic        clk_sys_i;
  logic        srst_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [15:0] pins_o;
  logic [31:0] exp_q[$];
  logic [31:0] r;
  int          num_errors;
  int          num_checks;
  int          cnt[16];

  pwm_wave_outputs #(.PINS(16)) i_dut (
    .clk_sys_i        (clk_sys_i),
    .srst_i           (srst_i),
    .avs_address_i    (avs_address_i),
    .avs_read_i       (avs_read_i),
    .avs_write_i      (avs_write_i),
    .avs_writedata_i  (avs_writedata_i),
    .avs_byteenable_i (avs_byteenable_i),
    .avs_readdata_o   (avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .pins_o           (pins_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(string name, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_rng(string name, int e, int g, int tol);
    num_checks++;
    if (g < e - tol || g > e + tol) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", name, e, g);
    end
  endtask

  // Each master signal changes right after an edge and holds until waitrequest is low.
  task automatic bus_wr(logic [7:0] a, logic [31:0] d, logic [3:0] be = 4'hf);
    @(posedge clk_sys_i);
    avs_address_i    <= a;
    avs_writedata_i  <= d;
    avs_byteenable_i <= be;
    avs_write_i      <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask

  task automatic bus_rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_sys_i);
    exp_q.push_back(e);
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
  endtask

  // Counts the high cycles of every pin over 1000 clocks.
  task automatic measure();
    for (int i = 0; i < 16; i++) cnt[i] = 0;
    repeat (1000) begin
      @(posedge clk_sys_i);
      for (int i = 0; i < 16; i++) if (pins_o[i] === 1'b1) cnt[i]++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0) check("read_note", 32'h0, 32'hffff_ffff);
      else check("readdata", exp_q.pop_front(), avs_readdata_o);
    end
  end

  initial begin
    #200_000;
    num_errors++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst_i           = 1'b1;
    avs_address_i    = 8'h00;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h0;
    avs_byteenable_i = 4'h0;
    num_errors       = 0;
    num_checks       = 0;
    void'($urandom(94));
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    bus_rd(`PIN_EN_OFS, 32'h0);
    bus_rd(`PIN_SEL_OFS, 32'h0);
    bus_rd(`PWM_PERIOD_OFS, 32'h3e8);
    bus_rd(`PWM_DUTY_OFS, 32'h1f4);
    bus_rd(`SQ_STEP_OFS, 32'h0);
    bus_rd(8'h20, 32'h0);
    for (int i = 0; i < 16; i++) bus_rd(`SQ_DUTY_BASE + 8'(4 * i), 32'h80);
    r = $urandom;
    bus_wr(`PIN_SEL_OFS, r);
    bus_rd(`PIN_SEL_OFS, {16'h0, r[15:0]});
    bus_wr(`PIN_EN_OFS, 32'hffff_ffff, 4'h1);
    bus_rd(`PIN_EN_OFS, 32'h00ff);
    bus_wr(`PWM_PERIOD_OFS, 32'h0);
    bus_rd(`PWM_PERIOD_OFS, 32'h1);
    bus_wr(8'h20, 32'hffff_ffff);
    bus_rd(8'h20, 32'h0);
    // The phase has never moved, so each square pin shows only whether its duty is zero.
    bus_wr(`PIN_EN_OFS, 32'hffff);
    bus_wr(`PIN_SEL_OFS, 32'hffff);
    for (int i = 0; i < 16; i++) bus_wr(`SQ_DUTY_BASE + 8'(4 * i), i[0] ? 32'h33 : 32'h0);
    repeat (5) @(posedge clk_sys_i);
    bus_rd(`STATUS_OFS, 32'h0001_aaaa);
    repeat (20) @(posedge clk_sys_i);
    bus_rd(`STATUS_OFS, 32'h0001_aaaa);
    for (int i = 0; i < 16; i++) bus_wr(`SQ_DUTY_BASE + 8'(4 * i), 32'(16 * i + 8));
    bus_wr(`SQ_STEP_OFS, 32'hffff_ffff);
    bus_rd(`SQ_STEP_OFS, 32'h147a_e147);
    // A step of one sixty-fourth of a turn gives a 64-clock period, fine enough for every duty.
    bus_wr(`SQ_STEP_OFS, 32'h0400_0000);
    measure();
    for (int i = 0; i < 16; i++) begin
      check_rng("square_high", (16 * i + 8) * 1000 / 256, cnt[i], 25);
    end
    r = $urandom;
    bus_wr(`PIN_SEL_OFS, 32'h0);
    bus_wr(`PIN_EN_OFS, r);
    bus_wr(`PWM_DUTY_OFS, 32'h0);
    repeat (4) @(posedge clk_sys_i);
    bus_rd(`STATUS_OFS, 32'h0);
    bus_wr(`PWM_PERIOD_OFS, 32'd10);
    bus_wr(`PWM_DUTY_OFS, 32'd10);
    repeat (4) @(posedge clk_sys_i);
    bus_rd(`STATUS_OFS, {15'h0, 1'b1, r[15:0]});
    bus_wr(`PIN_EN_OFS, 32'hffff);
    bus_wr(`PWM_DUTY_OFS, 32'd3);
    measure();
    check_rng("pwm_high", 300, cnt[0], 20);
    check_rng("pwm_high", 300, cnt[15], 20);
    bus_wr(`PWM_PERIOD_OFS, 32'd2);
    bus_wr(`PWM_DUTY_OFS, 32'd1);
    measure();
    check_rng("pwm_high", 500, cnt[7], 20);
    end_sim();
  end

endmodule // pwm_wave_outputs_test
